// [core/scc_map.svh]
// Register offsets, field positions, reset values and timing counts of the supply and CAN control.
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH

`define SCC_CMD_WRITE      2'h1
`define SCC_ADDR_SUPPLY    5'h0F
`define SCC_ADDR_CAN       5'h10
`define SCC_FRAME_BITS     5'h10

`define SCC_SUPPLY_RESET   8'h00
`define SCC_SUPPLY_MASK    8'h1F
`define SCC_CAN_RESET      8'h80
`define SCC_CAN_MASK       8'hF9

`define SCC_SUP_MODE_HI    4
`define SCC_SUP_MODE_LO    3
`define SCC_BAL_EN_BIT     2
`define SCC_BAL_AUTO_BIT   1
`define SCC_OFF_EN_BIT     0
`define SCC_CAN_MODE_HI    7
`define SCC_CAN_MODE_LO    6
`define SCC_SLEW_HI        5
`define SCC_SLEW_LO        4
`define SCC_WAKE_SEL_BIT   3
`define SCC_FAULT_INT_BIT  0

`define SCC_CLK_PERIOD_NS  10
`define SCC_BLANK_TIME_NS  1000000
`define SCC_BLANK_CYCLES   ((`SCC_BLANK_TIME_NS + `SCC_CLK_PERIOD_NS - 1) / `SCC_CLK_PERIOD_NS)
`define SCC_FAULT_PULSES   3'h5

`endif

// [core/scc_pkg.sv]
// Types shared by the supply and CAN control block.
package scc_pkg;

    typedef enum logic [1:0] {
        SCC_SUP_OFF,
        SCC_SUP_ON_QUIET,
        SCC_SUP_ON_FLAGS,
        SCC_SUP_ON_PROTECT
    } scc_supply_mode_t;

    typedef enum logic [1:0] {
        SCC_CAN_SLEEP_NOWAKE,
        SCC_CAN_RX_ONLY,
        SCC_CAN_SLEEP_WAKE,
        SCC_CAN_TX_RX
    } scc_can_mode_t;

    typedef enum logic [1:0] {
        SCC_SLEW_FAST,
        SCC_SLEW_MEDIUM,
        SCC_SLEW_SLOW
    } scc_slew_t;

endpackage : scc_pkg

// [core/scc_regs.sv]
// Supply and CAN control registers behind a 16-bit serial port, with their control outputs.
`timescale 1ns/1ns
`include "scc_map.svh"
module scc_regs #(
    parameter int BLANK_CYCLES = `SCC_BLANK_CYCLES
) (
    // Clock and reset
    input  wire logic                     clock_in,
    input  wire logic                     rst_n_in,
    // Serial port
    input  wire logic                     sclk_in,
    input  wire logic                     cs_n_in,
    input  wire logic                     mosi_in,
    output logic                          miso_out,
    // Supply monitoring and low-power request
    input  wire logic                     undervoltage_flag_in,
    input  wire logic                     overcurrent_flag_in,
    input  wire logic                     load_high_in,
    input  wire logic                     low_power_req_in,
    // CAN side
    input  wire logic                     normal_mode_in,
    input  wire logic                     can_fault_in,
    input  wire logic                     can_tx_input_in,
    // Supply controls
    output logic                          can_supply_ctl_out,
    output logic                          undervoltage_flag_out,
    output logic                          overcurrent_flag_out,
    output logic                          ballast_on_out,
    output logic                          low_power_grant_out,
    // CAN controls
    output scc_pkg::scc_can_mode_t        can_mode_out,
    output scc_pkg::scc_slew_t            slew_out,
    output logic                          wake_single_out,
    output logic                          can_fault_irq_out
);
    import scc_pkg::*;

    logic [9:0] raw;
    logic [9:0] syn;
    assign raw = {overcurrent_flag_in, undervoltage_flag_in, load_high_in, low_power_req_in,
                  normal_mode_in, can_fault_in, can_tx_input_in, cs_n_in, sclk_in, mosi_in};

    // Every input pin except the clock and reset, the serial clock included, is resampled before any logic sees it.
    // Each stage resets to its pin's idle level, so no false edge follows reset.
    scc_sync #(.WIDTH(10), .RESET_VALUE(10'h00C)) u_sync (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .async_in (raw),
        .sync_out (syn)
    );

    wire ovc   = syn[9];
    wire uv    = syn[8];
    wire load  = syn[7];
    wire lpreq = syn[6];
    wire norm  = syn[5];
    wire fault = syn[4];
    wire txd   = syn[3];
    wire csn   = syn[2];
    wire sclk  = syn[1];
    wire mosi  = syn[0];

    logic sclk_d;
    logic csn_d;
    logic norm_d;
    logic txd_d;
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            sclk_d <= 1'b0;
            csn_d  <= 1'b1;
            norm_d <= 1'b0;
            txd_d  <= 1'b1;
        end else begin
            sclk_d <= sclk;
            csn_d  <= csn;
            norm_d <= norm;
            txd_d  <= txd;
        end
    end

    wire sclk_rise = sclk & ~sclk_d;
    wire sclk_fall = ~sclk & sclk_d;
    wire cs_fall   = ~csn & csn_d;
    wire cs_rise   = csn & ~csn_d;
    wire norm_rise = norm & ~norm_d;
    wire tx_dom    = ~txd & txd_d;

    // Serial frame: command in bits 15-14, address in 13-9, parity in 8, data in 7-0.
    logic [15:0] rx_shift;
    logic [15:0] tx_shift;
    logic [4:0]  bit_cnt;
    logic [4:0]  last_addr;
    logic [7:0]  supply_regulator_ctl;
    logic [7:0]  can_transceiver_ctl;

    wire [4:0] rx_addr   = rx_shift[13:9];
    wire       frame_ok  = cs_rise && bit_cnt == `SCC_FRAME_BITS
                           && rx_shift[15:14] == `SCC_CMD_WRITE;
    wire       wr_supply = frame_ok && rx_addr == `SCC_ADDR_SUPPLY;
    wire       wr_can    = frame_ok && rx_addr == `SCC_ADDR_CAN;
    wire [7:0] readback  = (last_addr == `SCC_ADDR_SUPPLY) ? supply_regulator_ctl :
                           (last_addr == `SCC_ADDR_CAN)    ? can_transceiver_ctl  : 8'h00;

    // The reply carries the register addressed by the previous complete write frame, so reads lag one frame.
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rx_shift <= 16'h0000;
            tx_shift <= 16'h0000;
            bit_cnt  <= 5'h00;
        end else if (cs_fall) begin
            bit_cnt  <= 5'h00;
            tx_shift <= {8'h00, readback};
        end else if (!csn && sclk_rise) begin
            rx_shift <= {rx_shift[14:0], mosi};
            if (bit_cnt != `SCC_FRAME_BITS) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end else if (!csn && sclk_fall) begin
            tx_shift <= {tx_shift[14:0], 1'b0};
        end
    end
    assign miso_out = tx_shift[15];

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            supply_regulator_ctl <= `SCC_SUPPLY_RESET;
            can_transceiver_ctl  <= `SCC_CAN_RESET;
            last_addr            <= 5'h00;
        end else begin
            if (frame_ok) begin
                last_addr <= rx_addr;
            end
            if (wr_supply) begin
                supply_regulator_ctl <= rx_shift[7:0] & `SCC_SUPPLY_MASK;
            end
            if (wr_can) begin
                can_transceiver_ctl <= rx_shift[7:0] & `SCC_CAN_MASK;
            end
        end
    end

    // Supply regulator: blanking restarts whenever the mode field is rewritten.
    wire [1:0] sup_mode  = supply_regulator_ctl[`SCC_SUP_MODE_HI:`SCC_SUP_MODE_LO];
    wire       sup_off   = sup_mode == SCC_SUP_OFF;
    wire       sup_flags = sup_mode[1];
    wire       sup_prot  = sup_mode == SCC_SUP_ON_PROTECT;
    logic [31:0] blank_cnt;
    logic        blank_done;
    logic        shutdown;
    wire         trip = sup_prot && blank_done && (uv || ovc);
    wire         next_supply_on = !sup_off && !shutdown;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            blank_cnt  <= 32'h0000_0000;
            blank_done <= 1'b0;
            shutdown   <= 1'b0;
        end else begin
            if (sup_off || wr_supply) begin
                blank_cnt  <= 32'h0000_0000;
                blank_done <= 1'b0;
            end else if (!blank_done) begin
                blank_cnt  <= blank_cnt + 32'h0000_0001;
                blank_done <= blank_cnt == 32'(BLANK_CYCLES - 1);
            end
            // A trip in the same cycle as a rewrite still latches the shutdown.
            if (trip) begin
                shutdown <= 1'b1;
            end else if (wr_supply) begin
                shutdown <= 1'b0;
            end
        end
    end

    wire next_lp_grant = lpreq && supply_regulator_ctl[`SCC_OFF_EN_BIT];
    wire next_ballast  = supply_regulator_ctl[`SCC_BAL_EN_BIT]
                         || (supply_regulator_ctl[`SCC_BAL_AUTO_BIT] && load);

    // CAN mode is applied only on entry to normal mode; the first entry forces sleep with wake.
    logic           entered_once;
    scc_can_mode_t  next_can_mode;
    assign next_can_mode = !entered_once ? SCC_CAN_SLEEP_WAKE
        : scc_can_mode_t'(can_transceiver_ctl[`SCC_CAN_MODE_HI:`SCC_CAN_MODE_LO]);
    wire [1:0] slew_fld  = can_transceiver_ctl[`SCC_SLEW_HI:`SCC_SLEW_LO];
    scc_slew_t next_slew;
    assign next_slew = slew_fld[1] ? SCC_SLEW_SLOW
                     : (slew_fld[0] ? SCC_SLEW_MEDIUM : SCC_SLEW_FAST);

    // Bus fault: count dominant transmit edges while a failure is present.
    logic [2:0] fault_cnt;
    wire        fault_known = fault_cnt == `SCC_FAULT_PULSES;
    wire        next_irq    = fault && (can_transceiver_ctl[`SCC_FAULT_INT_BIT] || fault_known);

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            fault_cnt    <= 3'h0;
            entered_once <= 1'b0;
            can_mode_out <= SCC_CAN_SLEEP_WAKE;
        end else begin
            if (!fault) begin
                fault_cnt <= 3'h0;
            end else if (tx_dom && !fault_known) begin
                fault_cnt <= fault_cnt + 3'h1;
            end
            if (norm_rise) begin
                entered_once <= 1'b1;
                can_mode_out <= next_can_mode;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            can_supply_ctl_out    <= 1'b0;
            undervoltage_flag_out <= 1'b0;
            overcurrent_flag_out  <= 1'b0;
            ballast_on_out        <= 1'b0;
            low_power_grant_out   <= 1'b0;
            slew_out              <= SCC_SLEW_FAST;
            wake_single_out       <= 1'b0;
            can_fault_irq_out     <= 1'b0;
        end else begin
            can_supply_ctl_out    <= next_supply_on;
            undervoltage_flag_out <= sup_flags && blank_done && uv;
            overcurrent_flag_out  <= sup_flags && blank_done && ovc;
            ballast_on_out        <= next_ballast;
            low_power_grant_out   <= next_lp_grant;
            slew_out              <= next_slew;
            wake_single_out       <= can_transceiver_ctl[`SCC_WAKE_SEL_BIT];
            can_fault_irq_out     <= next_irq;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    chk_supply_off_mode: assert property (sup_off |=> !can_supply_ctl_out)
        else $error("CAN supply on while mode is off");
    chk_protect_trip_off: assert property (trip && !wr_supply ##1 !wr_supply
        |=> !can_supply_ctl_out)
        else $error("Protected supply not shut down after fault");
    chk_quiet_no_flags: assert property (sup_mode == SCC_SUP_ON_QUIET
        |=> !undervoltage_flag_out && !overcurrent_flag_out)
        else $error("Flags reported in quiet mode");
    chk_ballast_forced: assert property (supply_regulator_ctl[`SCC_BAL_EN_BIT]
        |=> ballast_on_out)
        else $error("Ballast not on while enabled");
    chk_ballast_auto_off: assert property (!supply_regulator_ctl[`SCC_BAL_EN_BIT]
        && !supply_regulator_ctl[`SCC_BAL_AUTO_BIT] |=> !ballast_on_out)
        else $error("Ballast on with both controls clear");
    chk_lp_refused: assert property (!supply_regulator_ctl[`SCC_OFF_EN_BIT]
        |=> !low_power_grant_out)
        else $error("Supply-off granted without permission");
    chk_fault_early_irq: assert property (fault && can_transceiver_ctl[`SCC_FAULT_INT_BIT]
        |=> can_fault_irq_out)
        else $error("Early fault interrupt missing");
    chk_fault_late_irq: assert property (!can_transceiver_ctl[`SCC_FAULT_INT_BIT]
        && fault_cnt < `SCC_FAULT_PULSES |=> !can_fault_irq_out)
        else $error("Fault interrupt before five pulses");
    chk_first_normal_sleep: assert property (norm_rise && !entered_once
        |=> can_mode_out == SCC_CAN_SLEEP_WAKE)
        else $error("First normal entry did not force sleep with wake");
    chk_later_normal_mode: assert property (norm_rise && entered_once
        |=> can_mode_out == $past(can_transceiver_ctl[7:6]))
        else $error("CAN mode not taken from field on entry");
    chk_slew_slow_map: assert property (can_transceiver_ctl[`SCC_SLEW_HI]
        |=> slew_out == SCC_SLEW_SLOW)
        else $error("Slew field high bit not mapped to slow");
endmodule : scc_regs

// [core/scc_sync.sv]
// Two-stage synchroniser for a vector of unrelated asynchronous inputs.
`timescale 1ns/1ns
module scc_sync #(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input  wire logic             clock_in,
    input  wire logic             rst_n_in,
    // Signals
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            stage1   <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : scc_sync

// [tb/scc_host_model.sv]
// Host-side serial master model that shifts 16-bit frames into the control registers.
`timescale 1ns/1ns
module scc_host_model (
    // Serial port
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      mosi_out,
    input  wire logic miso_in
);
    logic [15:0] reply;

    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
        reply    = 16'h0000;
    end

    // Sends a frame MSB first; fewer edges than sixteen give a truncated frame.
    task automatic send(input logic [15:0] frame, input int edges);
        int i;
        // Called at a falling clock edge, so every serial edge lands on one as well.
        cs_n_out = 1'b0;
        #80;
        for (i = 15; i > 15 - edges; i--) begin
            mosi_out = frame[i];
            #40;
            sclk_out = 1'b1;
            reply    = {reply[14:0], miso_in};
            #40;
            sclk_out = 1'b0;
        end
        #80;
        cs_n_out = 1'b1;
        // A released data line shows the inverse, so a stale bit cannot pass as valid.
        mosi_out = ~mosi_out;
        #80;
    endtask : send
endmodule : scc_host_model

// [tb/scc_regs_tb_top.sv]
// Self-checking testbench of the supply and CAN control registers.
`timescale 1ns/1ns
`include "scc_map.svh"
module scc_regs_tb_top;
    import scc_pkg::*;
    logic          clock_in, rst_n_in, sclk, cs_n, mosi, miso;
    logic          uv_in, oc_in, load_in, lp_req_in, normal_in, fault_in, tx_in;
    logic          supply_on, uv_out, oc_out, ballast, lp_grant, wake_single, irq;
    scc_can_mode_t can_mode;
    scc_slew_t     slew;
    int            mismatches;
    int            tests_run;

    initial clock_in = 1'b0;
    always #5 clock_in = ~clock_in;

    scc_host_model scc_host_model_inst (
        .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));

    // A short blanking time keeps the flag scenarios brief.
    scc_regs #(.BLANK_CYCLES(20)) scc_regs_inst (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .mosi_in(mosi), .miso_out(miso), .undervoltage_flag_in(uv_in),
        .overcurrent_flag_in(oc_in), .load_high_in(load_in), .low_power_req_in(lp_req_in),
        .normal_mode_in(normal_in), .can_fault_in(fault_in), .can_tx_input_in(tx_in),
        .can_supply_ctl_out(supply_on), .undervoltage_flag_out(uv_out),
        .overcurrent_flag_out(oc_out), .ballast_on_out(ballast),
        .low_power_grant_out(lp_grant), .can_mode_out(can_mode), .slew_out(slew),
        .wake_single_out(wake_single), .can_fault_irq_out(irq));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge clock_in);
    endtask : cyc

    task automatic wr(input logic [4:0] addr, input logic [7:0] data);
        scc_host_model_inst.send({`SCC_CMD_WRITE, addr, 1'b0, data}, 16);
        cyc(6);
    endtask : wr

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic t_ballast();
        wr(`SCC_ADDR_SUPPLY, 8'h04);
        check(ballast, 8'h01);
        wr(`SCC_ADDR_SUPPLY, 8'h02);
        check(ballast, 8'h00);
        load_in = 1'b1;
        cyc(6);
        check(ballast, 8'h01);
        wr(`SCC_ADDR_SUPPLY, 8'h00);
        check(ballast, 8'h00);
        load_in = 1'b0;
    endtask : t_ballast

    task automatic t_low_power();
        lp_req_in = 1'b1;
        cyc(6);
        check(lp_grant, 8'h00);
        wr(`SCC_ADDR_SUPPLY, 8'h01);
        check(lp_grant, 8'h01);
        wr(`SCC_ADDR_SUPPLY, 8'h00);
        check(lp_grant, 8'h00);
        lp_req_in = 1'b0;
    endtask : t_low_power

    task automatic t_supply();
        uv_in = 1'b1;
        wr(`SCC_ADDR_SUPPLY, 8'h08);
        cyc(30);
        check({supply_on, uv_out}, 8'h02);
        wr(`SCC_ADDR_SUPPLY, 8'h10);
        check({supply_on, uv_out}, 8'h02);
        cyc(30);
        check({supply_on, uv_out}, 8'h03);
        uv_in = 1'b0;
        oc_in = 1'b1;
        wr(`SCC_ADDR_SUPPLY, 8'h18);
        check(supply_on, 8'h01);
        cyc(30);
        check(supply_on, 8'h00);
        check(oc_out, 8'h01);
        oc_in = 1'b0;
        wr(`SCC_ADDR_SUPPLY, 8'h18);
        check(supply_on, 8'h01);
        wr(`SCC_ADDR_SUPPLY, 8'h00);
        check(supply_on, 8'h00);
    endtask : t_supply

    task automatic t_refused();
        // Read command, unmapped address and a truncated frame must all leave the bank alone.
        scc_host_model_inst.send({2'b00, `SCC_ADDR_SUPPLY, 1'b0, 8'h04}, 16);
        scc_host_model_inst.send({`SCC_CMD_WRITE, 5'h0E, 1'b0, 8'h04}, 16);
        scc_host_model_inst.send({`SCC_CMD_WRITE, `SCC_ADDR_SUPPLY, 1'b0, 8'h04}, 15);
        cyc(6);
        check(ballast, 8'h00);
    endtask : t_refused

    task automatic t_can_mode();
        int i;
        scc_slew_t exp_slew;
        wr(`SCC_ADDR_CAN, 8'hC0);
        normal_in = 1'b1;
        cyc(6);
        check(can_mode, SCC_CAN_SLEEP_WAKE);
        for (i = 0; i < 4; i++) begin
            wr(`SCC_ADDR_CAN, {i[1:0], i[1:0], i[0], 3'b000});
            normal_in = 1'b0;
            cyc(4);
            normal_in = 1'b1;
            cyc(6);
            check(can_mode, i[1:0]);
            exp_slew = (i == 0) ? SCC_SLEW_FAST : (i == 1) ? SCC_SLEW_MEDIUM : SCC_SLEW_SLOW;
            check(slew, exp_slew);
            check(wake_single, i[0]);
        end
        // A field write while already in normal mode waits for the next entry.
        wr(`SCC_ADDR_CAN, 8'h00);
        check(can_mode, SCC_CAN_TX_RX);
    endtask : t_can_mode

    task automatic t_fault();
        int k;
        wr(`SCC_ADDR_CAN, 8'h00);
        fault_in = 1'b1;
        for (k = 1; k <= 5; k++) begin
            tx_in = 1'b0;
            cyc(6);
            check(irq, (k == 5));
            tx_in = 1'b1;
            cyc(3);
        end
        fault_in = 1'b0;
        cyc(6);
        check(irq, 8'h00);
        wr(`SCC_ADDR_CAN, 8'h01);
        fault_in = 1'b1;
        cyc(6);
        check(irq, 8'h01);
        fault_in = 1'b0;
        cyc(6);
        check(irq, 8'h00);
    endtask : t_fault

    task automatic t_readback();
        // Each reply carries the register addressed by the previous accepted frame.
        wr(`SCC_ADDR_SUPPLY, 8'hFF);
        wr(`SCC_ADDR_CAN, 8'hFF);
        check(scc_host_model_inst.reply[15:8], 8'h00);
        check(scc_host_model_inst.reply[7:0], 8'h1F);
        scc_host_model_inst.send({2'b00, `SCC_ADDR_CAN, 1'b0, 8'h00}, 16);
        cyc(6);
        check(scc_host_model_inst.reply[7:0], 8'hF9);
    endtask : t_readback

    task automatic t_reset();
        // A second reset must restore both registers and re-arm the forced first entry.
        normal_in = 1'b0;
        rst_n_in  = 1'b0;
        cyc(4);
        rst_n_in  = 1'b1;
        cyc(4);
        check({supply_on, ballast, wake_single, slew}, 8'h00);
        check(can_mode, SCC_CAN_SLEEP_WAKE);
        wr(`SCC_ADDR_CAN, 8'hC0);
        check(scc_host_model_inst.reply[7:0], 8'h00);
        normal_in = 1'b1;
        cyc(6);
        check(can_mode, SCC_CAN_SLEEP_WAKE);
    endtask : t_reset

    initial begin
        repeat (100000) @(posedge clock_in);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        mismatches = 0;
        tests_run  = 0;
        {rst_n_in, uv_in, oc_in, load_in, lp_req_in, normal_in, fault_in} = 7'h00;
        tx_in = 1'b1;
        cyc(16);
        rst_n_in = 1'b1;
        cyc(4);
        check(can_mode, SCC_CAN_SLEEP_WAKE);
        check({supply_on, ballast, lp_grant, irq}, 8'h00);
        t_ballast();
        t_low_power();
        t_supply();
        t_refused();
        t_can_mode();
        t_fault();
        t_readback();
        t_reset();
        tally_and_finish();
    end
endmodule : scc_regs_tb_top
